// file: hdl/trc_cmd_decoder.sv
`timescale 1ns/1ps
module trc_cmd_decoder (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_link_clk,
  input wire logic i_link_start,
  input wire logic i_link_stop,
  input wire logic i_link_byte_vld,
  input wire logic [7:0] i_link_byte,
  input wire logic i_link_rd_ack,
  output logic o_link_ack,
  output logic [7:0] o_link_tx_byte,
  input wire logic [15:0] i_temperature,
  input wire logic [7:0] i_count_remain,
  input wire logic [7:0] i_count_per_c,
  input wire logic [7:0] i_status,
  input wire logic [55:0] i_clock_regs,
  input wire logic [31:0] i_alarm_regs,
  input wire logic i_clock_alarm_hit,
  output logic [7:0] o_config,
  output logic [15:0] o_low_threshold_reg,
  output logic [15:0] o_high_threshold_reg,
  output logic o_conv_start,
  output logic o_conv_run,
  output trc_pkg::trc_rtc_wr_t o_rtc_wr,
  output logic o_clock_run,
  output logic o_clock_12h,
  output logic o_clock_pm,
  output logic o_clock_alarm_flag,
  output logic o_temp_alarm_flag,
  output logic o_alarm_output
);
  import trc_pkg::*;

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic first_q;
  logic addressed_q;
  logic rd_q;
  logic l_tgl_q;
  trc_evt_t l_evt_q;
  logic c_tgl_s1_q;
  logic c_tgl_s2_q;
  logic c_tgl_s3_q;
  logic addr_hit;

  assign addr_hit = (i_link_byte[7:1] == TRC_DEV_ADDR[7:1]);

  // Frame tracking; START always reopens address phase
  always_ff @(posedge i_link_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      first_q <= 1'b0;
      addressed_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else if (i_link_start)
    begin
      first_q <= 1'b1;
      addressed_q <= 1'b0;
    end
    else if (i_link_stop)
    begin
      first_q <= 1'b0;
      addressed_q <= 1'b0;
    end
    else if (i_link_byte_vld && first_q)
    begin
      first_q <= 1'b0;
      addressed_q <= addr_hit;
      rd_q <= i_link_byte[0];
    end
  end

  // Ack for the byte just received
  always_ff @(posedge i_link_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_link_ack <= 1'b0;
    else if (i_link_byte_vld)
      o_link_ack <= first_q ? addr_hit : (addressed_q && !rd_q);
  end

  // Event word and toggle toward the core
  always_ff @(posedge i_link_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      l_evt_q <= '{kind: EV_NONE, data: 8'h00};
      l_tgl_q <= 1'b0;
    end
    else if (i_link_start)
    begin
      l_evt_q <= '{kind: EV_START, data: 8'h00};
      l_tgl_q <= !l_tgl_q;
    end
    else if (i_link_stop)
    begin
      l_evt_q <= '{kind: EV_STOP, data: 8'h00};
      l_tgl_q <= !l_tgl_q;
    end
    else if (i_link_byte_vld && first_q && addr_hit)
    begin
      l_evt_q <= '{kind: EV_ADDR, data: i_link_byte};
      l_tgl_q <= !l_tgl_q;
    end
    else if (i_link_byte_vld && !first_q && addressed_q && !rd_q)
    begin
      l_evt_q <= '{kind: EV_WR, data: i_link_byte};
      l_tgl_q <= !l_tgl_q;
    end
    else if (i_link_rd_ack && addressed_q && rd_q)
    begin
      l_evt_q <= '{kind: EV_RD_NEXT, data: 8'h00};
      l_tgl_q <= !l_tgl_q;
    end
  end

  // Read byte from core; word is stable once the toggle arrives
  logic c_tgl_q;
  logic [7:0] c_tx_q;

  always_ff @(posedge i_link_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      c_tgl_s1_q <= 1'b0;
      c_tgl_s2_q <= 1'b0;
      c_tgl_s3_q <= 1'b0;
      o_link_tx_byte <= TRC_PAD_BYTE;
    end
    else
    begin
      c_tgl_s1_q <= c_tgl_q;
      c_tgl_s2_q <= c_tgl_s1_q;
      c_tgl_s3_q <= c_tgl_s2_q;
      if (c_tgl_s2_q != c_tgl_s3_q)
        o_link_tx_byte <= c_tx_q;
    end
  end

  // ----------------------------------------
  // Core domain: event crossing
  // ----------------------------------------
  logic l_tgl_s1_q;
  logic l_tgl_s2_q;
  logic l_tgl_s3_q;
  logic ev_stb;
  trc_evt_t ev;

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      l_tgl_s1_q <= 1'b0;
      l_tgl_s2_q <= 1'b0;
      l_tgl_s3_q <= 1'b0;
    end
    else
    begin
      l_tgl_s1_q <= l_tgl_q;
      l_tgl_s2_q <= l_tgl_s1_q;
      l_tgl_s3_q <= l_tgl_s2_q;
    end
  end

  assign ev_stb = (l_tgl_s2_q != l_tgl_s3_q);
  assign ev = l_evt_q;

  // ----------------------------------------
  // Command state
  // ----------------------------------------
  trc_state_t state_q;
  logic [7:0] cmd_q;
  logic rw_q;
  logic known_cmd;
  logic ev_wr;
  logic ev_next;

  always_comb
  begin
    case (ev.data)
      TRC_CMD_CFG, TRC_CMD_MEM, TRC_CMD_TEMP, TRC_CMD_CNT, TRC_CMD_SLOPE,
      TRC_CMD_HI, TRC_CMD_LO, TRC_CMD_CLK, TRC_CMD_CALM: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  end

  assign ev_wr = ev_stb && (ev.kind == EV_WR) && (state_q == ST_DATA);
  assign ev_next = ev_stb && (ev.kind == EV_RD_NEXT) && (state_q == ST_DATA);

  // Command sequencer; cmd survives repeated START for read-back
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      rw_q <= 1'b0;
    end
    else if (ev_stb)
    begin
      case (ev.kind)
        EV_START, EV_STOP: state_q <= ST_IDLE;
        EV_ADDR:
        begin
          rw_q <= ev.data[0];
          state_q <= ev.data[0] ? ST_DATA : ST_CMD;
        end
        EV_WR:
        begin
          if (state_q == ST_CMD)
          begin
            if (known_cmd)
            begin
              cmd_q <= ev.data;
              state_q <= ST_DATA;
            end
            else
              state_q <= ST_SKIP;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // ----------------------------------------
  // Byte index and pointers
  // ----------------------------------------
  logic [1:0] idx_q;
  logic addr_set_q;
  logic [4:0] mem_ptr_q;
  logic [2:0] rtc_ptr_q;
  logic [2:0] rtc_last;
  logic new_cmd;
  logic rtc_cmd;

  assign new_cmd = ev_stb && (ev.kind == EV_WR) && (state_q == ST_CMD) && known_cmd;
  assign rtc_cmd = (cmd_q == TRC_CMD_CLK) || (cmd_q == TRC_CMD_CALM);
  assign rtc_last = (cmd_q == TRC_CMD_CLK) ? TRC_CLK_LAST : TRC_CALM_LAST;

  // Pointer steps only on a written byte or a master-acked read
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      idx_q <= 2'h0;
      addr_set_q <= 1'b0;
      mem_ptr_q <= 5'h00;
      rtc_ptr_q <= 3'h0;
    end
    else if (new_cmd)
    begin
      idx_q <= 2'h0;
      addr_set_q <= 1'b0;
    end
    else if (ev_stb && (ev.kind == EV_ADDR) && ev.data[0])
      idx_q <= 2'h0; // register reads restart at first byte
    else if ((ev_wr && !rw_q) || (ev_next && rw_q))
    begin
      if (idx_q != 2'h3)
        idx_q <= idx_q + 2'h1;
      if (!addr_set_q && !rw_q && ((cmd_q == TRC_CMD_MEM) || rtc_cmd))
      begin
        addr_set_q <= 1'b1;
        mem_ptr_q <= ev.data[4:0];
        rtc_ptr_q <= (ev.data[2:0] > rtc_last) ? 3'h0 : ev.data[2:0];
      end
      else if (cmd_q == TRC_CMD_MEM)
        mem_ptr_q <= mem_ptr_q + 5'h01;
      else if (rtc_cmd)
        rtc_ptr_q <= (rtc_ptr_q == rtc_last) ? 3'h0 : rtc_ptr_q + 3'h1;
    end
  end

  // ----------------------------------------
  // Writable registers and SRAM
  // ----------------------------------------
  logic [7:0] sram_q [TRC_SRAM_DEPTH];
  logic [7:0] msb_q;
  logic data_wr;

  assign data_wr = ev_wr && !rw_q;

  always_ff @(posedge i_core_clk)
  begin
    if (data_wr && addr_set_q && (cmd_q == TRC_CMD_MEM))
      sram_q[mem_ptr_q] <= ev.data;
  end

  // Thresholds commit on the second byte, MSB held first
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_config <= TRC_CFG_RST;
      msb_q <= 8'h00;
      o_low_threshold_reg <= TRC_LO_RST;
      o_high_threshold_reg <= TRC_HI_RST;
    end
    else if (data_wr)
    begin
      if ((cmd_q == TRC_CMD_CFG) && (idx_q == 2'h0))
        o_config <= ev.data;
      if (idx_q == 2'h0)
        msb_q <= ev.data;
      if ((cmd_q == TRC_CMD_LO) && (idx_q == 2'h1))
        o_low_threshold_reg <= {msb_q, ev.data};
      if ((cmd_q == TRC_CMD_HI) && (idx_q == 2'h1))
        o_high_threshold_reg <= {msb_q, ev.data};
    end
  end

  // Clock and alarm writes go to the calendar as one-cycle strobes
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rtc_wr <= '0;
      o_clock_run <= 1'b0;
      o_clock_12h <= 1'b0;
      o_clock_pm <= 1'b0;
    end
    else
    begin
      o_rtc_wr <= '{vld: data_wr && addr_set_q && rtc_cmd, alarm: (cmd_q == TRC_CMD_CALM),
                    idx: rtc_ptr_q, data: ev.data};
      if (data_wr && addr_set_q && (cmd_q == TRC_CMD_CLK))
      begin
        if (rtc_ptr_q == TRC_SEC_IDX)
          o_clock_run <= !ev.data[TRC_HALT_BIT];
        if (rtc_ptr_q == TRC_HOUR_IDX)
        begin
          o_clock_12h <= ev.data[TRC_12H_BIT];
          o_clock_pm <= ev.data[TRC_PM_BIT];
        end
      end
    end
  end

  // ----------------------------------------
  // Conversion control
  // ----------------------------------------
  logic cmd_go;
  logic cmd_halt;

  assign cmd_go = ev_stb && (ev.kind == EV_WR) && (state_q == ST_CMD) && (ev.data == TRC_CMD_GO);
  assign cmd_halt = ev_stb && (ev.kind == EV_WR) && (state_q == ST_CMD) && (ev.data == TRC_CMD_HALT);

  // One-shot mode gets a start pulse only; run level is continuous mode
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_conv_start <= 1'b0;
      o_conv_run <= 1'b0;
    end
    else
    begin
      o_conv_start <= cmd_go;
      if (cmd_go)
        o_conv_run <= !o_config[TRC_ONESHOT_BIT];
      else if (cmd_halt)
        o_conv_run <= 1'b0;
    end
  end

  // ----------------------------------------
  // Alarm flags
  // ----------------------------------------
  logic rtc_access;

  assign rtc_access = rtc_cmd && addr_set_q && (data_wr || ev_next);

  // Hardware set wins over an access clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_clock_alarm_flag <= 1'b0;
      o_temp_alarm_flag <= 1'b0;
      o_alarm_output <= 1'b0;
    end
    else
    begin
      if (i_clock_alarm_hit)
        o_clock_alarm_flag <= 1'b1;
      else if (rtc_access)
        o_clock_alarm_flag <= 1'b0;
      if ($signed(i_temperature) >= $signed(o_high_threshold_reg))
        o_temp_alarm_flag <= 1'b1;
      else if ($signed(i_temperature) <= $signed(o_low_threshold_reg))
        o_temp_alarm_flag <= 1'b0;
      o_alarm_output <= o_temp_alarm_flag || o_clock_alarm_flag;
    end
  end

  // ----------------------------------------
  // Read data toward the link
  // ----------------------------------------
  logic send_q;
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = TRC_PAD_BYTE;
    case (cmd_q)
      TRC_CMD_CFG: rd_byte = (idx_q == 2'h0) ? o_config : i_status;
      TRC_CMD_TEMP: rd_byte = (idx_q == 2'h0) ? i_temperature[15:8] : i_temperature[7:0];
      TRC_CMD_HI: rd_byte = (idx_q == 2'h0) ? o_high_threshold_reg[15:8] : o_high_threshold_reg[7:0];
      TRC_CMD_LO: rd_byte = (idx_q == 2'h0) ? o_low_threshold_reg[15:8] : o_low_threshold_reg[7:0];
      TRC_CMD_CNT: rd_byte = (idx_q == 2'h0) ? i_count_remain : TRC_PAD_BYTE;
      TRC_CMD_SLOPE: rd_byte = (idx_q == 2'h0) ? i_count_per_c : TRC_PAD_BYTE;
      TRC_CMD_MEM: rd_byte = sram_q[mem_ptr_q];
      TRC_CMD_CLK: rd_byte = i_clock_regs[rtc_ptr_q*8 +: 8];
      TRC_CMD_CALM: rd_byte = i_alarm_regs[rtc_ptr_q[1:0]*8 +: 8];
      default: rd_byte = TRC_PAD_BYTE;
    endcase
    if (idx_q > 2'h1)
      rd_byte = (cmd_q == TRC_CMD_MEM) || rtc_cmd ? rd_byte : TRC_PAD_BYTE;
  end

  // Byte is formed a cycle after the pointer moved
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      send_q <= 1'b0;
      c_tgl_q <= 1'b0;
      c_tx_q <= TRC_PAD_BYTE;
    end
    else
    begin
      send_q <= (ev_stb && (ev.kind == EV_ADDR) && ev.data[0]) || ev_next;
      if (send_q)
      begin
        c_tx_q <= rd_byte;
        c_tgl_q <= !c_tgl_q;
      end
    end
  end

endmodule

// file: shared/trc_pkg.sv
// Summary of operation
// - Low-threshold command, write: next two bytes load the low threshold register.
// - Memory command takes a start address, then reads or writes SRAM per direction.
// - SRAM pointer advances per byte and wraps from last location to first.
// - Pointer wrap happens after the byte at the last location is transferred and acknowledged.
// - Configuration write takes one byte; reads return configuration then status.
// - Begin-conversion starts conversion, no data; only way to resume after halt.
// - Halt-conversion stops continuous conversion, no data; idle until begin-conversion.
// - Read-temperature returns MSB first; one or two bytes may be read.
// - Threshold write takes exactly two bytes; read returns one or two bytes.
// - Device answers control byte 9Eh as write, same address with bit 0 as read.
// - Device acknowledges address, command and every written data byte.
// - Repeated START with new address byte begins a fresh command.
// - Seconds write loads seconds and controls clock run; zero enables.
// - Clock bytes ordered seconds..year; successive bytes address successive registers.
// - Hours byte carries hour, 12/24-hour mode and AM/PM indicator.
// - High-threshold command: write loads next two bytes, read returns stored value.
// - Read-counter returns one byte of residual count.
// - Read-slope returns one byte of counts per degree.
// - Clock-alarm access is addressed; any clock or alarm access clears alarm flag (here only data writes and master-acked reads after the address byte clear it).
package trc_pkg;

  // ----------------------------------------
  // Bus address and command codes
  // ----------------------------------------
  localparam logic [7:0] TRC_DEV_ADDR = 8'h9E;
  localparam logic [7:0] TRC_CMD_CFG = 8'hAC;
  localparam logic [7:0] TRC_CMD_MEM = 8'h17;
  localparam logic [7:0] TRC_CMD_GO = 8'hEE;
  localparam logic [7:0] TRC_CMD_HALT = 8'h22;
  localparam logic [7:0] TRC_CMD_TEMP = 8'hAA;
  localparam logic [7:0] TRC_CMD_CNT = 8'hA8;
  localparam logic [7:0] TRC_CMD_SLOPE = 8'hA9;
  localparam logic [7:0] TRC_CMD_HI = 8'hA1;
  localparam logic [7:0] TRC_CMD_LO = 8'hA2;
  localparam logic [7:0] TRC_CMD_CLK = 8'hC0;
  localparam logic [7:0] TRC_CMD_CALM = 8'hC7;

  // ----------------------------------------
  // Sizes, positions and reset values
  // ----------------------------------------
  localparam int TRC_SRAM_DEPTH = 32;
  localparam logic [2:0] TRC_CLK_LAST = 3'h6;
  localparam logic [2:0] TRC_CALM_LAST = 3'h3;
  localparam logic [2:0] TRC_SEC_IDX = 3'h0;
  localparam logic [2:0] TRC_HOUR_IDX = 3'h2;
  localparam int TRC_HALT_BIT = 7;
  localparam int TRC_12H_BIT = 6;
  localparam int TRC_PM_BIT = 5;
  localparam int TRC_ONESHOT_BIT = 0;
  localparam logic [7:0] TRC_CFG_RST = 8'h00;
  localparam logic [15:0] TRC_HI_RST = 16'h7F00;
  localparam logic [15:0] TRC_LO_RST = 16'h8000;
  localparam logic [7:0] TRC_PAD_BYTE = 8'hFF;

  typedef enum logic [2:0] {EV_NONE, EV_START, EV_STOP, EV_ADDR, EV_WR, EV_RD_NEXT} trc_evk_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_SKIP} trc_state_t;

  typedef struct packed {
    trc_evk_t kind;
    logic [7:0] data;
  } trc_evt_t;

  typedef struct packed {
    logic vld;
    logic alarm;
    logic [2:0] idx;
    logic [7:0] data;
  } trc_rtc_wr_t;

endpackage

// file: sim/trc_cmd_decoder_tb.sv
`timescale 1ns/1ps
module trc_cmd_decoder_tb;
  import trc_pkg::*;
  logic clk, lclk, rst_n, hit;
  logic [15:0] temp, lo, hi;
  logic [7:0] cnt, slope, stat, byt, tx, cfg, d, cv;
  logic [55:0] cregs;
  logic [31:0] aregs;
  logic start, stop, vld, rd_ack, ack;
  logic go, run, crun, h12, pm, caf, temp_alarm_flag, alarm_output;
  trc_rtc_wr_t rtc;
  logic [7:0] mem [32];
  logic [7:0] clog [8];
  logic [7:0] alog [4];
  logic [15:0] thr [2];
  int n_fail, n_checks, n_go;
  // ----
  // Clocks, phases unrelated
  // ----
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end
  trc_master_model m (.i_link_clk(lclk), .o_start(start), .o_stop(stop), .o_vld(vld), .o_rd_ack(rd_ack),
    .o_byte(byt));
  trc_cmd_decoder uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_link_clk(lclk), .i_link_start(start),
    .i_link_stop(stop), .i_link_byte_vld(vld), .i_link_byte(byt), .i_link_rd_ack(rd_ack),
    .o_link_ack(ack), .o_link_tx_byte(tx), .i_temperature(temp), .i_count_remain(cnt),
    .i_count_per_c(slope), .i_status(stat), .i_clock_regs(cregs), .i_alarm_regs(aregs),
    .i_clock_alarm_hit(hit), .o_config(cfg), .o_low_threshold_reg(lo), .o_high_threshold_reg(hi),
    .o_conv_start(go), .o_conv_run(run), .o_rtc_wr(rtc), .o_clock_run(crun), .o_clock_12h(h12),
    .o_clock_pm(pm), .o_clock_alarm_flag(caf), .o_temp_alarm_flag(temp_alarm_flag), .o_alarm_output(alarm_output));
  // Log core strobes; a missed pulse shows as a stale entry
  always @(posedge clk)
  begin
    if (go)
      n_go++;
    if (rtc.vld && rtc.alarm)
      alog[rtc.idx[1:0]] <= rtc.data;
    else if (rtc.vld)
      clog[rtc.idx] <= rtc.data;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] b);
    m.ev(2, b);
    chk("ack", 16'h0001, {15'h0000, ack});
  endtask
  task automatic cmd(input logic [7:0] c);
    m.ev(0, 8'h00);
    wr(TRC_DEV_ADDR);
    wr(c);
  endtask
  task automatic rd_open;
    m.ev(0, 8'h00);
    m.ev(2, TRC_DEV_ADDR | 8'h01);
  endtask
  task automatic rd(input logic [7:0] e, input bit nxt);
    chk("tx", {8'h00, e}, {8'h00, tx});
    if (nxt)
      m.ev(3, 8'h00);
  endtask
  task automatic core_wait;
    repeat (6) @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    results();
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    void'($urandom(32'hD67A));
    rst_n = 1'b0;
    hit = 1'b0;
    temp = 16'h1900;
    cnt = 8'($urandom);
    slope = 8'($urandom);
    stat = 8'($urandom);
    cregs = {24'($urandom), 32'($urandom)};
    aregs = $urandom;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge lclk);
    chk("cfg", {8'h00, TRC_CFG_RST}, {8'h00, cfg});
    chk("lo", TRC_LO_RST, lo);
    chk("hi", TRC_HI_RST, hi);
    chk("tx", {8'h00, TRC_PAD_BYTE}, {8'h00, tx});
    chk("out", 16'h0000, {14'h0000, run, alarm_output});
    // Foreign address: refused, frame ignored
    m.ev(0, 8'h00);
    m.ev(2, 8'h9C);
    chk("nak", 16'h0000, {15'h0000, ack});
    m.ev(2, TRC_CMD_CFG);
    m.ev(2, 8'h55);
    chk("cfg", 16'h0000, {8'h00, cfg});
    // Thresholds written MSB first, read back then padding
    thr[0] = 16'h3200;
    thr[1] = {1'b1, 15'($urandom)};
    for (int i = 0; i < 2; i++)
    begin
      cmd(i ? TRC_CMD_LO : TRC_CMD_HI);
      wr(thr[i][15:8]);
      wr(thr[i][7:0]);
      chk("thr", thr[i], i ? lo : hi);
      cmd(i ? TRC_CMD_LO : TRC_CMD_HI);
      rd_open();
      rd(thr[i][15:8], 1);
      rd(thr[i][7:0], 1);
      rd(TRC_PAD_BYTE, 0);
    end
    m.ev(1, 8'h00);
    // Config, conversion control, ignored bytes
    cv = 8'($urandom) & 8'hFE;
    cmd(TRC_CMD_CFG);
    wr(cv);
    chk("cfg", {8'h00, cv}, {8'h00, cfg});
    cmd(TRC_CMD_CFG);
    rd_open();
    rd(cv, 1);
    rd(stat, 0);
    cmd(TRC_CMD_GO);
    chk("run", 16'h0001, {15'h0000, run});
    cmd(TRC_CMD_HALT);
    wr(8'h5A);
    chk("run", 16'h0000, {15'h0000, run});
    cmd(8'h5A);
    wr(8'h00);
    chk("cfg", {8'h00, cv}, {8'h00, cfg});
    cmd(TRC_CMD_GO);
    chk("run", 16'h0001, {15'h0000, run});
    cmd(TRC_CMD_CFG);
    wr(8'h01);
    cmd(TRC_CMD_HALT);
    cmd(TRC_CMD_GO);
    cmd(TRC_CMD_GO);
    chk("go", 16'h0004, 16'(n_go));
    chk("run", 16'h0000, {15'h0000, run});
    // Measurement reads
    cmd(TRC_CMD_TEMP);
    rd_open();
    rd(temp[15:8], 1);
    rd(temp[7:0], 1);
    rd(TRC_PAD_BYTE, 0);
    cmd(TRC_CMD_CNT);
    rd_open();
    rd(cnt, 0);
    cmd(TRC_CMD_SLOPE);
    rd_open();
    rd(slope, 0);
    @(posedge clk);
    temp <= 16'h3300;
    core_wait();
    chk("taf", 16'h0003, {14'h0000, temp_alarm_flag, alarm_output});
    @(posedge clk);
    temp <= thr[1];
    core_wait();
    chk("taf", 16'h0000, {15'h0000, temp_alarm_flag});
    // SRAM: 33 bytes from 1Eh wrap onto the first
    cmd(TRC_CMD_MEM);
    wr(8'h1E);
    for (int k = 0; k < 33; k++)
    begin
      d = 8'($urandom);
      mem[(30 + k) % 32] = d;
      wr(d);
    end
    cmd(TRC_CMD_MEM);
    wr(8'h1E);
    rd_open();
    for (int k = 0; k < 33; k++)
      rd(mem[(30 + k) % 32], k < 32);
    // Clock set with alarm pending
    @(posedge clk);
    hit <= 1'b1;
    @(posedge clk);
    hit <= 1'b0;
    core_wait();
    chk("caf", 16'h0001, {15'h0000, caf});
    cmd(TRC_CMD_CLK);
    wr(8'h00);
    cregs[7:0] <= 8'h00;
    for (int k = 0; k < 7; k++)
      wr({8'h98, 8'h01, 8'h01, 8'h05, 8'h51, 8'h30, 8'h00} >> (8 * k));
    for (int k = 0; k < 7; k++)
      chk("clk", {8'h00, 8'({8'h98, 8'h01, 8'h01, 8'h05, 8'h51, 8'h30, 8'h00} >> (8 * k))}, {8'h00, clog[k]});
    chk("mode", 16'h0006, {13'h0000, crun, h12, pm});
    chk("caf", 16'h0000, {15'h0000, caf});
    cmd(TRC_CMD_CLK);
    wr(8'h02);
    wr(8'h71);
    wr(8'h06);
    chk("pm", 16'h0003, {14'h0000, h12, pm});
    chk("dow", 16'h0006, {8'h00, clog[3]});
    cmd(TRC_CMD_CLK);
    wr(8'h00);
    wr(8'h80);
    chk("run", 16'h0000, {15'h0000, crun});
    // Alarm registers wrap 3 to 0
    d = 8'($urandom);
    cmd(TRC_CMD_CALM);
    wr(8'h03);
    wr(8'h5C);
    wr(d);
    chk("alm", {8'h5C, d}, {alog[3], alog[0]});
    // Clock read also clears the flag
    @(posedge clk);
    hit <= 1'b1;
    @(posedge clk);
    hit <= 1'b0;
    m.gap = 30;
    cmd(TRC_CMD_CLK);
    wr(8'h01);
    rd_open();
    rd(cregs[15:8], 1);
    rd(cregs[23:16], 0);
    chk("caf", 16'h0000, {15'h0000, caf});
    m.ev(1, 8'h00);
    results();
  end
endmodule

// file: sim/trc_cmd_monitor.sv
`timescale 1ns/1ps
module trc_cmd_monitor (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_link_clk,
  input wire logic i_link_start,
  input wire logic i_link_byte_vld,
  input wire logic [7:0] i_link_byte,
  input wire logic o_link_ack,
  input wire logic [15:0] i_temperature,
  input wire logic i_clock_alarm_hit,
  input wire logic [15:0] o_high_threshold_reg,
  input wire logic o_conv_start,
  input wire logic o_conv_run,
  input wire trc_pkg::trc_rtc_wr_t o_rtc_wr,
  input wire logic o_clock_run,
  input wire logic o_clock_alarm_flag,
  input wire logic o_temp_alarm_flag,
  input wire logic o_alarm_output
);
  import trc_pkg::*;
  // ----
  // Helpers
  // ----
  logic first_q;
  logic sec_run;
  // Marks the control byte slot after a start
  always_ff @(posedge i_link_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      first_q <= 1'b0;
    else if (i_link_start)
      first_q <= 1'b1;
    else if (i_link_byte_vld)
      first_q <= 1'b0;
  end
  // Seconds write with run enabled
  assign sec_run = o_rtc_wr.vld && !o_rtc_wr.alarm && o_rtc_wr.idx == TRC_SEC_IDX && !o_rtc_wr.data[7];
  // ----
  // Properties
  // ----
  property p_addr_ack;
    @(posedge i_link_clk) disable iff (!i_reset_n)
    first_q && i_link_byte_vld && i_link_byte[7:1] == TRC_DEV_ADDR[7:1] |=> o_link_ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_addr_nak;
    @(posedge i_link_clk) disable iff (!i_reset_n)
    first_q && i_link_byte_vld && i_link_byte[7:1] != TRC_DEV_ADDR[7:1] |=> !o_link_ack;
  endproperty
  a_addr_nak: assert property (p_addr_nak) else $error("foreign address acked");
  property p_go_pulse;
    @(posedge i_core_clk) disable iff (!i_reset_n) o_conv_start |=> !o_conv_start;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("start pulse too long");
  property p_run_cause;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_conv_run) |-> o_conv_start || $past(o_conv_start);
  endproperty
  a_run_cause: assert property (p_run_cause) else $error("run without start");
  property p_wr_pulse;
    @(posedge i_core_clk) disable iff (!i_reset_n) o_rtc_wr.vld |=> !o_rtc_wr.vld;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("clock write too long");
  property p_caf_set;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_clock_alarm_hit |-> ##[1:2] o_clock_alarm_flag;
  endproperty
  a_caf_set: assert property (p_caf_set) else $error("clock alarm flag not set");
  property p_alarm_output_quiet;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (!o_clock_alarm_flag && !o_temp_alarm_flag) [*2] |-> !o_alarm_output;
  endproperty
  a_alarm_output_quiet: assert property (p_alarm_output_quiet) else $error("alarm without flag");
  property p_taf_rise;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_temp_alarm_flag) |-> $signed(i_temperature) >= $signed(o_high_threshold_reg);
  endproperty
  a_taf_rise: assert property (p_taf_rise) else $error("temp flag below limit");
  property p_clk_run;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_clock_run) |-> sec_run || $past(sec_run);
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock run without write");
  // Main scenarios reached
  c_go: cover property (@(posedge i_core_clk) o_conv_start);
  c_alm: cover property (@(posedge i_core_clk) o_rtc_wr.vld && o_rtc_wr.alarm);
  c_taf: cover property (@(posedge i_core_clk) $rose(o_temp_alarm_flag));
endmodule
bind trc_cmd_decoder trc_cmd_monitor u_mon (.*);

// file: sim/trc_master_model.sv
`timescale 1ns/1ps
module trc_master_model (
  input wire logic i_link_clk,
  output logic o_start,
  output logic o_stop,
  output logic o_vld,
  output logic o_rd_ack,
  output logic [7:0] o_byte
);
  // Spacing well above the crossing time; raise for a slow master
  int gap = 14;
  initial
  begin
    o_start = 1'b0;
    o_stop = 1'b0;
    o_vld = 1'b0;
    o_rd_ack = 1'b0;
    o_byte = 8'h00;
  end
  // One event strobe: 0 start, 1 stop, 2 byte, 3 read ack
  task automatic ev(input int k, input logic [7:0] b);
    @(posedge i_link_clk);
    o_byte <= b;
    o_start <= (k == 0);
    o_stop <= (k == 1);
    o_vld <= (k == 2);
    o_rd_ack <= (k == 3);
    @(posedge i_link_clk);
    o_start <= 1'b0;
    o_stop <= 1'b0;
    o_vld <= 1'b0;
    o_rd_ack <= 1'b0;
    // Stale data must not look valid
    o_byte <= ~b;
    repeat (gap) @(posedge i_link_clk);
  endtask
endmodule
